/* File: dv/cmd_handler_sva.sv */
// Assertions on the ports of the common command handler.
`timescale 1ns/10ps
module cmd_handler_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic [3:0] cmdCode,
  input wire logic [8:0] cmdArg,
  input wire logic cmdArgRoundUp,
  input wire logic gpibActive,
  input wire logic pendingBusy,
  input wire logic evPowerOn,
  input wire logic respReady,
  input wire logic cmdReady_r,
  input wire logic respValid_r,
  input wire logic [7:0] respChar_r,
  input wire logic factoryReset_r,
  input wire logic [7:0] eventEnable_r,
  input wire logic [7:0] eventStatus_r,
  input wire logic [7:0] srqEnable_r
);
  logic take;
  logic [9:0] sum;
  assign take = cmdValid & cmdReady_r;
  assign sum = {1'b0, cmdArg} + {9'h000, cmdArgRoundUp};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_ese_load: assert property (
    take && cmdCode == 4'h7 && sum < 10'h100 |=>
    eventEnable_r == 8'($past(sum))) else $error("mask not loaded");
  a_ese_refuse: assert property (
    take && cmdCode == 4'h7 && sum > 10'h0FF |=>
    $stable(eventEnable_r) && eventStatus_r[4]) else $error("bad mask");
  a_sre_load: assert property (
    take && cmdCode == 4'hA && sum < 10'h100 |=>
    srqEnable_r == (8'($past(sum)) & 8'h33)) else $error("srq mask");
  a_serial_unused: assert property (
    !gpibActive [*2] |-> (eventStatus_r & 8'h43) == 8'h00)
    else $error("unused bit set");
  a_pon_set: assert property (
    evPowerOn |=> eventStatus_r[7]) else $error("power-on bit");
  a_opc_wait: assert property (
    take && cmdCode == 4'h4 ##1 pendingBusy [*2] |=> !respValid_r)
    else $error("early answer");
  a_resp_hold: assert property (
    respValid_r && !respReady |=> respValid_r && $stable(respChar_r))
    else $error("response dropped");
  a_rst_keep: assert property (
    take && cmdCode == 4'h1 |=> factoryReset_r && $stable(eventEnable_r))
    else $error("reset wrong");
endmodule
bind common_command_status_handler cmd_handler_sva i_cmd_handler_sva (
  .clk, .reset_n, .cmdValid, .cmdCode, .cmdArg, .cmdArgRoundUp,
  .gpibActive, .pendingBusy, .evPowerOn, .respReady, .cmdReady_r,
  .respValid_r, .respChar_r, .factoryReset_r, .eventEnable_r,
  .eventStatus_r, .srqEnable_r);

/* File: dv/host_model.sv */
// Remote host model that takes response characters, promptly or slowly.
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  output logic respReady
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r + 2'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign respReady = !slow || cnt_r == 2'h3;
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the common command handler.
`timescale 1ns/10ps
module tb_top;
  import common_cmd_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmdValid = 1'b0;
  logic [3:0] cmdCode = 4'h0;
  logic [8:0] cmdArg = 9'h000;
  logic cmdArgRoundUp = 1'b0;
  logic gpibActive = 1'b1;
  logic pendingBusy = 1'b0;
  logic selfTestDone = 1'b0;
  logic ramFault = 1'b0;
  logic eepromFault = 1'b0;
  logic [6:0] ev = 7'h00;
  logic slow = 1'b0;
  logic respReady;
  logic cmdReady_r, respValid_r, respLast_r, factoryReset_r;
  logic selfTestStart_r, clearStatus_r, eventSummary_r;
  string idText = "MAKER,MODEL,0,V1.00";
  logic [7:0] respChar_r, eventEnable_r, eventStatus_r, srqEnable_r;
  logic [16:0] seed = 17'h16631;
  logic [8:0] q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  common_command_status_handler i_common_command_status_handler (
    .clk, .reset_n, .cmdValid, .cmdCode, .cmdArg, .cmdArgRoundUp,
    .gpibActive, .pendingBusy, .selfTestDone, .ramFault, .eepromFault,
    .evPowerOn(ev[6]), .evUserRequest(ev[5]), .evCommandError(ev[4]),
    .evExecError(ev[3]), .evDeviceError(ev[2]), .evQueryError(ev[1]),
    .evControlRequest(ev[0]), .respReady, .cmdReady_r, .respValid_r,
    .respChar_r, .respLast_r, .factoryReset_r, .selfTestStart_r,
    .clearStatus_r, .eventEnable_r, .eventStatus_r, .srqEnable_r,
    .eventSummary_r);
  host_model i_host_model (.clk, .reset_n, .slow, .respReady);
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic num(input int v);
    if (v > 99) q.push_back({1'b0, 8'(8'h30 + v / 100)});
    if (v > 9) q.push_back({1'b0, 8'(8'h30 + v / 10 % 10)});
    q.push_back({1'b1, 8'(8'h30 + v % 10)});
  endtask
  task automatic cmd(input logic [3:0] c, input logic [8:0] a = 9'h000,
                     input logic r = 1'b0);
    @(negedge clk);
    while (cmdReady_r !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdArg <= a;
    cmdArgRoundUp <= r;
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic drain();
    while (q.size() != 0) @(negedge clk);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (respValid_r === 1'b1 && respReady === 1'b1) begin
      chk({respLast_r, respChar_r}, q.size() > 0 ? q.pop_front() : 9'h1FF);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] a;
    logic r;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk(eventEnable_r, 9'h000);
    chk(srqEnable_r, 9'h000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      a = seed[7:0];
      r = seed[8] & (a != 8'hFF);
      slow = seed[9];
      cmd(CMD_ESE, {1'b0, a}, r);
      chk(eventEnable_r, a + r);
      num(a + r);
      cmd(CMD_ESE_Q);
      drain();
    end
    cmd(CMD_ESE, 9'h0FF, 1'b1);
    chk(eventEnable_r, a + r);
    pulse(7'h50);
    num(176);
    cmd(CMD_ESR_Q);
    drain();
    num(0);
    cmd(CMD_ESR_Q);
    drain();
    $display("test enable and status done");
    @(posedge clk);
    pendingBusy <= 1'b1;
    cmd(CMD_OPC);
    repeat (4) @(negedge clk);
    chk(eventStatus_r, 9'h000);
    @(posedge clk);
    pendingBusy <= 1'b0;
    repeat (3) @(negedge clk);
    chk(eventStatus_r, 9'h001);
    @(posedge clk);
    pendingBusy <= 1'b1;
    num(1);
    cmd(CMD_OPC_Q);
    repeat (4) @(negedge clk);
    chk(9'(q.size()), 9'h001);
    @(posedge clk);
    pendingBusy <= 1'b0;
    drain();
    num(1);
    cmd(CMD_ESR_Q);
    drain();
    cmd(CMD_WAI);
    chk(cmdReady_r, 9'h001);
    $display("test synchronisation done");
    for (int k = 0; k < 4; k++) begin
      num(k);
      cmd(CMD_TST_Q);
      chk(selfTestStart_r, 9'h001);
      repeat (3) @(posedge clk);
      selfTestDone <= 1'b1;
      ramFault <= k[0];
      eepromFault <= k[1];
      @(posedge clk);
      selfTestDone <= 1'b0;
      drain();
    end
    foreach (idText[j]) begin
      q.push_back({j == 18, 8'(idText[j])});
    end
    cmd(CMD_IDN_Q);
    drain();
    $display("test self-test and identity done");
    cmd(CMD_ESE, 9'h024);
    cmd(CMD_RST);
    chk(factoryReset_r, 9'h001);
    chk(eventEnable_r, 9'h024);
    cmd(CMD_SRE, 9'h0FF);
    chk(srqEnable_r, 9'h033);
    num(51);
    cmd(CMD_SRE_Q);
    drain();
    cmd(4'hC);
    chk(eventStatus_r, 9'h020);
    chk(eventSummary_r, 9'h001);
    cmd(CMD_CLS);
    chk(clearStatus_r, 9'h001);
    chk(eventStatus_r, 9'h000);
    chk(eventEnable_r, 9'h024);
    chk(eventSummary_r, 9'h000);
    $display("test reset and clear done");
    @(posedge clk);
    gpibActive <= 1'b0;
    pulse(7'h7F);
    chk(eventStatus_r, 9'h0BC);
    cmd(CMD_OPC);
    repeat (3) @(negedge clk);
    chk(eventStatus_r, 9'h0BC);
    num(188);
    cmd(CMD_ESR_Q);
    drain();
    cmd(CMD_CLS);
    chk(eventEnable_r, 9'h000);
    $display("test serial link done");
    tally_and_finish();
  end
endmodule

/* File: rtl/common_cmd_params.svh */
// Offsets, field positions, reset values and masks of the command handler.
`ifndef COMMON_CMD_PARAMS_SVH
`define COMMON_CMD_PARAMS_SVH

`define EV_PON 7
`define EV_URQ 6
`define EV_CME 5
`define EV_EXE 4
`define EV_DDE 3
`define EV_QYE 2
`define EV_RQC 1
`define EV_OPC 0

`define EVENT_ENABLE_RESET 8'h00
`define EVENT_STATUS_RESET 8'h00
`define SRQ_ENABLE_RESET 8'h00
`define SRQ_ENABLE_KEEP 8'h33
`define EVENT_MASK_GPIB 8'hFF
`define EVENT_MASK_SERIAL 8'hBC
`define ARG_MAX 9'h0FF
`define OPC_ANSWER 8'h01
`define TST_RAM_BIT 0
`define TST_EEPROM_BIT 1
`define ID_FIXED_FIELD ",0,"

`endif

/* File: rtl/common_cmd_pkg.sv */
// Types shared by the common command handler and its testbench.
package common_cmd_pkg;

  typedef enum logic [3:0] {
    CMD_IDN_Q,
    CMD_RST,
    CMD_TST_Q,
    CMD_OPC,
    CMD_OPC_Q,
    CMD_WAI,
    CMD_CLS,
    CMD_ESE,
    CMD_ESE_Q,
    CMD_ESR_Q,
    CMD_SRE,
    CMD_SRE_Q
  } cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_DONE,
    ST_SELF_TEST,
    ST_RESPOND
  } state_type;

endpackage

/* File: rtl/common_command_status_handler.sv */
// Common command handler with standard event status and enable registers.
// Operation
// RL1: Numbers arrive as NR1, NR2 or NR3.
// RL2: Character responses are sent upper case.
// RL3: Identity answers maker, model, 0, version.
// RL4: Reset restores factory settings, initial display.
// RL5: Reset keeps communications state untouched.
// RL6: Self-test answers 0 to 3 faults.
// RL7: Operation complete sets bit 0 when idle.
// RL8: Operation complete query answers 1 when idle.
// RL9: Wait is accepted and does nothing.
// RL10: Clear status clears events, keeps queue.
// RL11: Event enable loads and reports 8-bit mask.
// RL12: Event enable mask is zero after power-on.
// RL13: Event status query answers, then clears.
// RL14: Serial link leaves bits 6, 1, 0 unused.
// RL15: Unused event bits stay zero always.
// RL16: Service enable keeps bits 0,1,4,5, starts zero.
`timescale 1ns/10ps
`include "common_cmd_params.svh"

module common_command_status_handler
  import common_cmd_pkg::*;
#(
  parameter int MAKER_LEN = 5,
  parameter logic [8*MAKER_LEN-1:0] MAKER_NAME = "maker",
  parameter int MODEL_LEN = 5,
  parameter logic [8*MODEL_LEN-1:0] MODEL_NAME = "model",
  parameter int VERSION_LEN = 5,
  parameter logic [8*VERSION_LEN-1:0] VERSION_NAME = "v1.00"
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic [3:0] cmdCode,
  input wire logic [8:0] cmdArg,
  input wire logic cmdArgRoundUp,
  input wire logic gpibActive,
  input wire logic pendingBusy,
  input wire logic selfTestDone,
  input wire logic ramFault,
  input wire logic eepromFault,
  input wire logic evPowerOn,
  input wire logic evUserRequest,
  input wire logic evCommandError,
  input wire logic evExecError,
  input wire logic evDeviceError,
  input wire logic evQueryError,
  input wire logic evControlRequest,
  input wire logic respReady,
  output logic cmdReady_r,
  output logic respValid_r,
  output logic [7:0] respChar_r,
  output logic respLast_r,
  output logic factoryReset_r,
  output logic selfTestStart_r,
  output logic clearStatus_r,
  output logic [7:0] eventEnable_r,
  output logic [7:0] eventStatus_r,
  output logic [7:0] srqEnable_r,
  output logic eventSummary_r
);

  localparam int ID_LEN = MAKER_LEN + MODEL_LEN + VERSION_LEN + 4;
  // RL3: four-field identity
  localparam logic [8*ID_LEN-1:0] ID_TEXT =
    {MAKER_NAME, ",", MODEL_NAME, `ID_FIXED_FIELD, VERSION_NAME};

  generate
    if (MAKER_LEN < 1 || MODEL_LEN < 1 || VERSION_LEN < 1) begin : g_chk
      $error("Identity fields must not be empty.");
    end
  endgenerate

  state_type state_r, state_nxt;
  cmd_type held_r, held_nxt;
  logic cmdReady_nxt, factoryReset_nxt, selfTestStart_nxt, clearStatus_nxt;
  logic [7:0] eventEnable_nxt, eventStatus_nxt, srqEnable_nxt;
  logic eventSummary_nxt;
  logic serStart, serText, serBusy;
  logic [7:0] serValue;
  logic [7:0] ifaceMask, newEvents, argByte;
  logic [9:0] argSum;
  logic argBad;

  // RL1: rounded NRf value
  assign argSum = {1'b0, cmdArg} + {9'h000, cmdArgRoundUp};
  assign argBad = argSum > {1'b0, `ARG_MAX};
  assign argByte = argSum[7:0];

  // RL14: bits in use per interface
  assign ifaceMask = gpibActive ? `EVENT_MASK_GPIB : `EVENT_MASK_SERIAL;

  always_comb begin
    state_nxt = state_r;
    held_nxt = held_r;
    factoryReset_nxt = 1'b0;
    selfTestStart_nxt = 1'b0;
    clearStatus_nxt = 1'b0;
    eventEnable_nxt = eventEnable_r;
    srqEnable_nxt = srqEnable_r;
    eventStatus_nxt = eventStatus_r;
    serStart = 1'b0;
    serText = 1'b0;
    serValue = 8'h00;
    newEvents = 8'h00;
    newEvents[`EV_PON] = evPowerOn;
    newEvents[`EV_URQ] = evUserRequest;
    newEvents[`EV_CME] = evCommandError;
    newEvents[`EV_EXE] = evExecError;
    newEvents[`EV_DDE] = evDeviceError;
    newEvents[`EV_QYE] = evQueryError;
    newEvents[`EV_RQC] = evControlRequest;
    unique case (state_r)
      ST_IDLE: begin
        if (cmdValid && cmdReady_r) begin
          held_nxt = cmd_type'(cmdCode);
          unique case (cmd_type'(cmdCode))
            CMD_IDN_Q: begin
              serStart = 1'b1;
              serText = 1'b1;
              state_nxt = ST_RESPOND;
            end
            // RL4: factory defaults
            // RL5: comms kept
            CMD_RST: factoryReset_nxt = 1'b1;
            CMD_TST_Q: begin
              selfTestStart_nxt = 1'b1;
              state_nxt = ST_SELF_TEST;
            end
            CMD_OPC, CMD_OPC_Q: state_nxt = ST_WAIT_DONE;
            // RL9: accepted, no effect
            CMD_WAI: ;
            // RL10: clear status
            CMD_CLS: begin
              clearStatus_nxt = 1'b1;
              eventStatus_nxt = 8'h00;
              if (!gpibActive) begin
                eventEnable_nxt = `EVENT_ENABLE_RESET;
                srqEnable_nxt = `SRQ_ENABLE_RESET;
              end
            end
            // RL11: load event mask
            CMD_ESE: begin
              if (argBad) begin
                newEvents[`EV_EXE] = 1'b1;
              end else begin
                eventEnable_nxt = argByte;
              end
            end
            CMD_ESE_Q: begin
              serStart = 1'b1;
              serValue = eventEnable_r;
              state_nxt = ST_RESPOND;
            end
            // RL13: report then clear
            CMD_ESR_Q: begin
              serStart = 1'b1;
              serValue = eventStatus_r;
              eventStatus_nxt = 8'h00;
              state_nxt = ST_RESPOND;
            end
            // RL16: ignored bits dropped
            CMD_SRE: begin
              if (argBad) begin
                newEvents[`EV_EXE] = 1'b1;
              end else begin
                srqEnable_nxt = argByte & `SRQ_ENABLE_KEEP;
              end
            end
            CMD_SRE_Q: begin
              serStart = 1'b1;
              serValue = srqEnable_r;
              state_nxt = ST_RESPOND;
            end
            default: newEvents[`EV_CME] = 1'b1;
          endcase
        end
      end
      ST_WAIT_DONE: begin
        if (!pendingBusy) begin
          if (held_r == CMD_OPC_Q) begin
            // RL8: answer 1
            serStart = 1'b1;
            serValue = `OPC_ANSWER;
            state_nxt = ST_RESPOND;
          end else begin
            // RL7: set complete bit
            newEvents[`EV_OPC] = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_SELF_TEST: begin
        if (selfTestDone) begin
          // RL6: fault code 0-3
          serStart = 1'b1;
          serValue = 8'h00;
          serValue[`TST_RAM_BIT] = ramFault;
          serValue[`TST_EEPROM_BIT] = eepromFault;
          state_nxt = ST_RESPOND;
        end
      end
      ST_RESPOND: begin
        if (!serBusy && !serStart && respValid_r == 1'b0) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // RL15: unused bits never set
    eventStatus_nxt = (eventStatus_nxt | newEvents) & ifaceMask;
    eventSummary_nxt = |(eventStatus_nxt & eventEnable_nxt);
    cmdReady_nxt = (state_nxt == ST_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      held_r <= CMD_WAI;
      cmdReady_r <= 1'b0;
      factoryReset_r <= 1'b0;
      selfTestStart_r <= 1'b0;
      clearStatus_r <= 1'b0;
      // RL12: mask zero at power-on
      eventEnable_r <= `EVENT_ENABLE_RESET;
      eventStatus_r <= `EVENT_STATUS_RESET;
      srqEnable_r <= `SRQ_ENABLE_RESET;
      eventSummary_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      held_r <= held_nxt;
      cmdReady_r <= cmdReady_nxt;
      factoryReset_r <= factoryReset_nxt;
      selfTestStart_r <= selfTestStart_nxt;
      clearStatus_r <= clearStatus_nxt;
      eventEnable_r <= eventEnable_nxt;
      eventStatus_r <= eventStatus_nxt;
      srqEnable_r <= srqEnable_nxt;
      eventSummary_r <= eventSummary_nxt;
    end
  end

  response_serializer #(
    .ID_LEN(ID_LEN),
    .ID_TEXT(ID_TEXT)
  ) u_serializer (
    .clk(clk),
    .reset_n(reset_n),
    .start(serStart),
    .textMode(serText),
    .value(serValue),
    .respReady(respReady),
    .respValid_r(respValid_r),
    .respChar_r(respChar_r),
    .respLast_r(respLast_r),
    .busy_r(serBusy)
  );

endmodule

/* File: rtl/response_serializer.sv */
// Turns an integer or the identification text into response characters.
`timescale 1ns/10ps
`include "common_cmd_params.svh"

module response_serializer #(
  parameter int ID_LEN = 16,
  parameter logic [8*ID_LEN-1:0] ID_TEXT = "ABCDEFGHIJKLMNOP"
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic textMode,
  input wire logic [7:0] value,
  input wire logic respReady,
  output logic respValid_r,
  output logic [7:0] respChar_r,
  output logic respLast_r,
  output logic busy_r
);

  localparam int IW = $clog2(ID_LEN + 1);
  localparam logic [IW-1:0] TEXT_LAST = IW'(ID_LEN - 1);

  generate
    if (ID_LEN < 5) begin : g_len_check
      $error("Identification text too short for four fields.");
    end
  endgenerate

  // Character parameters always leave in upper case.
  function automatic logic [7:0] upper(input logic [7:0] c);
    if (c >= 8'h61 && c <= 8'h7A) begin
      upper = c - 8'h20;
    end else begin
      upper = c;
    end
  endfunction

  function automatic logic [7:0] ascii_digit(input logic [3:0] d);
    ascii_digit = 8'h30 + {4'h0, d};
  endfunction

  logic textMode_r, textMode_nxt;
  logic [IW-1:0] index_r, index_nxt;
  logic [IW-1:0] last_r, last_nxt;
  logic [7:0] digits_r [3];
  logic [7:0] digits_nxt [3];
  logic respValid_nxt, respLast_nxt, busy_nxt;
  logic [7:0] respChar_nxt;
  logic [7:0] curChar;
  logic [IW-1:0] curIndex;

  always_comb begin
    textMode_nxt = textMode_r;
    index_nxt = index_r;
    last_nxt = last_r;
    digits_nxt = digits_r;
    busy_nxt = busy_r;
    respValid_nxt = respValid_r;
    respChar_nxt = respChar_r;
    respLast_nxt = respLast_r;
    curIndex = index_r;
    curChar = 8'h00;
    if (!busy_r && start) begin
      textMode_nxt = textMode;
      index_nxt = '0;
      curIndex = '0;
      busy_nxt = 1'b1;
      // RL1: NR1 integer form
      if (value >= 8'd100) begin
        digits_nxt[0] = ascii_digit(4'(value / 8'd100));
        digits_nxt[1] = ascii_digit(4'((value / 8'd10) % 8'd10));
        digits_nxt[2] = ascii_digit(4'(value % 8'd10));
        last_nxt = IW'(2);
      end else if (value >= 8'd10) begin
        digits_nxt[0] = ascii_digit(4'(value / 8'd10));
        digits_nxt[1] = ascii_digit(4'(value % 8'd10));
        digits_nxt[2] = 8'h30;
        last_nxt = IW'(1);
      end else begin
        digits_nxt[0] = ascii_digit(value[3:0]);
        digits_nxt[1] = 8'h30;
        digits_nxt[2] = 8'h30;
        last_nxt = '0;
      end
      if (textMode) begin
        last_nxt = TEXT_LAST;
      end
    end else if (busy_r && respValid_r && respReady) begin
      if (respLast_r) begin
        busy_nxt = 1'b0;
      end
      index_nxt = index_r + IW'(1);
      curIndex = index_r + IW'(1);
    end
    if (busy_nxt) begin
      // RL2: upper-case text
      if (textMode_nxt) begin
        curChar = upper(ID_TEXT[8*(ID_LEN-1-int'(curIndex)) +: 8]);
      end else begin
        curChar = digits_nxt[curIndex[1:0]];
      end
    end
    respValid_nxt = busy_nxt;
    respChar_nxt = busy_nxt ? curChar : 8'h00;
    respLast_nxt = busy_nxt && (curIndex == last_nxt);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      textMode_r <= 1'b0;
      index_r <= '0;
      last_r <= '0;
      digits_r <= '{8'h30, 8'h30, 8'h30};
      busy_r <= 1'b0;
      respValid_r <= 1'b0;
      respChar_r <= 8'h00;
      respLast_r <= 1'b0;
    end else begin
      textMode_r <= textMode_nxt;
      index_r <= index_nxt;
      last_r <= last_nxt;
      digits_r <= digits_nxt;
      busy_r <= busy_nxt;
      respValid_r <= respValid_nxt;
      respChar_r <= respChar_nxt;
      respLast_r <= respLast_nxt;
    end
  end

endmodule
